// ---- verilog/sar_ctrl_pkg.sv ----
// sar_ctrl_pkg: constants, types and state codes shared by the converter control block.
// assumes a single 100 MHz system clock and a host that writes one control byte per strobe.
package sar_ctrl_pkg;

   // control byte as latched from the data pins, most significant bit first
   typedef struct packed {
      logic power_clock_sel_hi;      // upper power/clock select bit
      logic power_clock_sel_lo;      // lower power/clock select bit
      logic acquisition_method_bit;  // 0 internal, 1 external acquisition
      logic single_ended_select;     // 0 pseudo-differential, 1 single-ended
      logic unipolar_select;         // 0 bipolar, 1 unipolar
      logic channel_addr_bit2;       // channel address, high bit
      logic channel_addr_bit1;       // channel address, middle bit
      logic channel_addr_bit0;       // channel address, low bit
   } ctrl_byte_s;

   // power/clock select encodings
   localparam logic [1:0] PC_FULL_PD = 2'h0;   // full power-down
   localparam logic [1:0] PC_STANDBY = 2'h1;   // standby power-down
   localparam logic [1:0] PC_INT_CLK = 2'h2;   // normal, internal clock
   localparam logic [1:0] PC_EXT_CLK = 2'h3;   // normal, external clock

   // value after reset: normal operation with the external clock
   localparam logic [7:0] CTRL_RESET = 8'hC0;

   // analog input channels and result width
   localparam int NUM_CHANNELS = 6;
   localparam int RESULT_BITS = 12;

   // falling conversion-clock edges from the write to hold, internal acquisition
   localparam logic [2:0] ACQ_FALL_EDGES = 3'h4;
   // conversion-clock cycles per conversion: one input swap plus one per bit
   localparam logic [3:0] CONV_CYCLES = 4'hD;
   // first trial code of the successive approximation
   localparam logic [11:0] SAR_FIRST_TRIAL = 12'h800;
   localparam logic [3:0] SAR_TOP_BIT = 4'hB;

   // internal conversion clock timing
   localparam int SYS_CLK_PERIOD_NS = 10;
   localparam int INT_CLK_PERIOD_NS = 250;
   localparam int INT_CLK_HALF_CYCLES = (INT_CLK_PERIOD_NS / 2) / SYS_CLK_PERIOD_NS;
   localparam logic [7:0] INT_CLK_HALF_LAST = 8'(INT_CLK_HALF_CYCLES - 1);

   // sequencer states
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_TRACK_EXT,
      ST_TRACK_INT,
      ST_CONVERT
   } seq_state_e;

endpackage : sar_ctrl_pkg

// ---- verilog/conv_clock_edges.sv ----
// conv_clock_edges: one-cycle pulse on each falling edge of the conversion clock.
// assumes the external clock pin is synchronous to the system clock; the internal
// clock is made here by dividing the system clock.
`timescale 1ns/100ps

module conv_clock_edges (
   input wire logic clk_in,          // system clock
   input wire logic rst_n_in,        // asynchronous reset, active low
   input wire logic ext_mode_in,     // 1 selects the pin, 0 the internal divider
   input wire logic clk_pin_in,      // external conversion clock pin
   output logic fall_pulse_out       // one-cycle pulse per falling edge
);

   logic pin_q;          // previous sample of the pin
   logic [7:0] div_q;    // half-period counter
   logic phase_q;        // internal clock level

   // previous pin level for edge detection
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pin_q <= 1'b0;
      end else begin
         pin_q <= clk_pin_in;
      end
   end

   // internal divider: phase toggles every half period
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         div_q <= 8'h00;
         phase_q <= 1'b0;
      end else if (div_q == sar_ctrl_pkg::INT_CLK_HALF_LAST) begin
         div_q <= 8'h00;
         phase_q <= ~phase_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end

   // falling edge of whichever clock the mode selects
   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fall_pulse_out <= 1'b0;
      end else if (ext_mode_in) begin
         fall_pulse_out <= pin_q & ~clk_pin_in;
      end else begin
         fall_pulse_out <= phase_q & (div_q == sar_ctrl_pkg::INT_CLK_HALF_LAST);
      end
   end

endmodule : conv_clock_edges

// ---- verilog/sar_adc_control_byte_track_hold.sv ----
// sar_adc_control_byte_track_hold: control-byte decode and track/hold sequencing
// for a 12-bit successive-approximation converter, with the approximation register.
// assumes host pins and comparator output are synchronous to CLOCK_IN; the analog
// switches, hold capacitor and comparator sit outside and follow the select outputs.
//
// Notes on behaviour
// - select bits 00: full power-down, keep clock mode
// - select bits 01: standby power-down, keep clock mode
// - other codes: normal, internal or external clock
// - code 10 selects internal clock; host ties pin
// - code 11 selects external clock; host drives it
// - external clock mode after reset
// - bit five: internal or write-ended acquisition
// - bit four: pseudo-differential or single-ended input
// - bit three: bipolar or unipolar input range
// - result straight binary unipolar, two's complement bipolar
// - low three bits address the positive channel
// - single-ended: channels zero to five, common negative
// - differential: adjacent pair, address picks positive member
// - differential: only the positive input is sampled
// - tracking starts on write strobe rising edge
// - external acquisition: next strobe rise with bit five clear starts hold
// - internal acquisition: hold on fourth clock fall
// - conversion swaps hold capacitor to negative input
// - next acquisition reconnects positive input for tracking
`timescale 1ns/100ps

module sar_adc_control_byte_track_hold (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic CS_N_IN,
   input wire logic WR_N_IN,
   input wire logic [7:0] DATA_IN,
   input wire logic CONV_CLK_IN,
   input wire logic COMPARATOR_IN,
   output logic [5:0] POS_SEL_OUT,
   output logic [5:0] NEG_SEL_OUT,
   output logic NEG_COMMON_OUT,
   output logic CAP_TO_POS_OUT,
   output logic CAP_TO_NEG_OUT,
   output logic FULL_POWER_DOWN_OUT,
   output logic STANDBY_OUT,
   output logic INT_CLK_MODE_OUT,
   output logic CONVERTING_OUT,
   output logic [11:0] DAC_CODE_OUT,
   output logic [11:0] RESULT_OUT,
   output logic RESULT_STROBE_OUT
);

   // one-hot channel decode, empty for the undefined addresses six and seven
   function automatic logic [5:0] chan_onehot(input logic [2:0] addr);
      logic [5:0] sel;
      sel = 6'h00;
      if (addr < 3'h6) begin
         sel[addr] = 1'b1;
      end
      return sel;
   endfunction : chan_onehot

   logic wr_n_q;                          // previous write strobe level
   logic [7:0] data_q;                    // byte captured while the strobe is low
   logic wr_rise;                         // strobe rising edge with chip select low
   sar_ctrl_pkg::ctrl_byte_s ctrl_q;      // latched control byte
   sar_ctrl_pkg::ctrl_byte_s ctrl_d;
   sar_ctrl_pkg::ctrl_byte_s wr_byte;     // byte of the current write
   logic [1:0] wr_pc;                     // power/clock code of the current write
   sar_ctrl_pkg::seq_state_e state_q;     // sequencer state
   sar_ctrl_pkg::seq_state_e state_d;
   logic ext_clk_q;                       // 1 external, 0 internal conversion clock
   logic fall;                            // conversion-clock falling edge pulse
   logic [2:0] acq_cnt_q;                 // falling edges seen while tracking
   logic [3:0] conv_cnt_q;                // conversion-clock cycles in conversion
   logic [3:0] bit_idx_q;                 // bit under trial
   logic [11:0] trial_q;                  // current trial code
   logic [11:0] trial_next;               // trial code after a decision
   logic conv_start;                      // hold taken, conversion begins
   logic conv_done;                       // last bit decided
   logic [2:0] addr_d;                    // channel address of the next byte
   logic [5:0] pos_d;                     // positive channel select, next
   logic [5:0] neg_d;                     // negative channel select, next

   assign wr_byte = sar_ctrl_pkg::ctrl_byte_s'(data_q);
   assign wr_pc = {wr_byte.power_clock_sel_hi, wr_byte.power_clock_sel_lo};
   assign wr_rise = ~wr_n_q & WR_N_IN & ~CS_N_IN;

   // conversion clock edges, from the pin or the internal divider
   conv_clock_edges u_edges (
      .clk_in(CLOCK_IN),
      .rst_n_in(RESET_N_IN),
      .ext_mode_in(ext_clk_q),
      .clk_pin_in(CONV_CLK_IN),
      .fall_pulse_out(fall)
   );

   // strobe history and byte capture while strobe and chip select are low
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         wr_n_q <= 1'b1;
         data_q <= 8'h00;
      end else begin
         wr_n_q <= WR_N_IN;
         if (!WR_N_IN && !CS_N_IN) begin
            data_q <= DATA_IN;
         end
      end
   end

   // next control byte: every write replaces it
   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_rise) begin
         ctrl_d = wr_byte;
      end
   end

   // control byte register
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ctrl_q <= sar_ctrl_pkg::ctrl_byte_s'(sar_ctrl_pkg::CTRL_RESET);
      end else begin
         ctrl_q <= ctrl_d;
      end
   end

   // clock mode: changed only by a normal-operation code
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         ext_clk_q <= 1'b1;
      end else if (wr_rise && wr_pc == sar_ctrl_pkg::PC_INT_CLK) begin
         ext_clk_q <= 1'b0;
      end else if (wr_rise && wr_pc == sar_ctrl_pkg::PC_EXT_CLK) begin
         ext_clk_q <= 1'b1;
      end
   end

   // power state outputs and clock mode flag
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         FULL_POWER_DOWN_OUT <= 1'b0;
         STANDBY_OUT <= 1'b0;
         INT_CLK_MODE_OUT <= 1'b0;
      end else begin
         if (wr_rise) begin
            // power-down codes leave the clock mode untouched
            FULL_POWER_DOWN_OUT <= (wr_pc == sar_ctrl_pkg::PC_FULL_PD);
            STANDBY_OUT <= (wr_pc == sar_ctrl_pkg::PC_STANDBY);
         end
         if (wr_rise && wr_pc == sar_ctrl_pkg::PC_INT_CLK) begin
            INT_CLK_MODE_OUT <= 1'b1;
         end else if (wr_rise && wr_pc == sar_ctrl_pkg::PC_EXT_CLK) begin
            INT_CLK_MODE_OUT <= 1'b0;
         end
      end
   end

   // sequencer next state
   always_comb begin
      state_d = state_q;
      conv_start = 1'b0;
      unique case (state_q)
         sar_ctrl_pkg::ST_TRACK_EXT: begin
            if (wr_rise && !wr_byte.acquisition_method_bit) begin
               // second strobe ends tracking; power bits may change here
               state_d = sar_ctrl_pkg::ST_CONVERT;
               conv_start = 1'b1;
            end else if (wr_rise && wr_pc[1]) begin
               state_d = sar_ctrl_pkg::ST_TRACK_EXT;
            end else if (wr_rise) begin
               state_d = sar_ctrl_pkg::ST_IDLE;
            end
         end
         sar_ctrl_pkg::ST_IDLE, sar_ctrl_pkg::ST_TRACK_INT, sar_ctrl_pkg::ST_CONVERT: begin
            if (wr_rise && !wr_pc[1]) begin
               // power-down byte aborts any activity
               state_d = sar_ctrl_pkg::ST_IDLE;
            end else if (wr_rise && wr_byte.acquisition_method_bit) begin
               state_d = sar_ctrl_pkg::ST_TRACK_EXT;
            end else if (wr_rise) begin
               // a new byte during conversion aborts it and tracks again
               state_d = sar_ctrl_pkg::ST_TRACK_INT;
            end else if (state_q == sar_ctrl_pkg::ST_TRACK_INT && fall &&
                         acq_cnt_q == sar_ctrl_pkg::ACQ_FALL_EDGES - 3'h1) begin
               state_d = sar_ctrl_pkg::ST_CONVERT;
               conv_start = 1'b1;
            end else if (state_q == sar_ctrl_pkg::ST_CONVERT && conv_done) begin
               state_d = sar_ctrl_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // sequencer state register
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         state_q <= sar_ctrl_pkg::ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // falling edges counted from the write that started internal acquisition
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         acq_cnt_q <= 3'h0;
      end else if (wr_rise) begin
         acq_cnt_q <= 3'h0;
      end else if (state_q == sar_ctrl_pkg::ST_TRACK_INT && fall) begin
         acq_cnt_q <= acq_cnt_q + 3'h1;
      end
   end

   // successive approximation step: keep or drop the bit, try the next one
   always_comb begin
      trial_next = trial_q;
      if (!COMPARATOR_IN) begin
         trial_next[bit_idx_q] = 1'b0;
      end
      if (bit_idx_q != 4'h0) begin
         trial_next[bit_idx_q - 4'h1] = 1'b1;
      end
   end

   // last decision on the thirteenth conversion-clock cycle
   assign conv_done = fall && conv_cnt_q == sar_ctrl_pkg::CONV_CYCLES - 4'h1;

   // approximation register: first cycle swaps the input, then one bit per cycle
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         conv_cnt_q <= 4'h0;
         bit_idx_q <= sar_ctrl_pkg::SAR_TOP_BIT;
         trial_q <= sar_ctrl_pkg::SAR_FIRST_TRIAL;
      end else if (conv_start) begin
         conv_cnt_q <= 4'h0;
         bit_idx_q <= sar_ctrl_pkg::SAR_TOP_BIT;
         trial_q <= sar_ctrl_pkg::SAR_FIRST_TRIAL;
      end else if (state_q == sar_ctrl_pkg::ST_CONVERT && fall) begin
         conv_cnt_q <= conv_cnt_q + 4'h1;
         if (conv_cnt_q != 4'h0) begin
            // cycle zero only settles the swapped input
            trial_q <= trial_next;
            if (bit_idx_q != 4'h0) begin
               bit_idx_q <= bit_idx_q - 4'h1;
            end
         end
      end
   end

   // result word in the format chosen by the range bit
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         RESULT_OUT <= 12'h000;
         RESULT_STROBE_OUT <= 1'b0;
      end else begin
         RESULT_STROBE_OUT <= 1'b0;
         if (state_q == sar_ctrl_pkg::ST_CONVERT && conv_done && !wr_rise) begin
            RESULT_STROBE_OUT <= 1'b1;
            if (ctrl_q.unipolar_select) begin
               RESULT_OUT <= trial_next;
            end else begin
               RESULT_OUT <= {~trial_next[11], trial_next[10:0]};
            end
         end
      end
   end

   // trial code to the capacitive array
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         DAC_CODE_OUT <= sar_ctrl_pkg::SAR_FIRST_TRIAL;
      end else if (conv_start) begin
         DAC_CODE_OUT <= sar_ctrl_pkg::SAR_FIRST_TRIAL;
      end else if (state_q == sar_ctrl_pkg::ST_CONVERT && fall && conv_cnt_q != 4'h0) begin
         DAC_CODE_OUT <= trial_next;
      end
   end

   // channel selects for the byte that will be in force next cycle
   always_comb begin
      addr_d = {ctrl_d.channel_addr_bit2, ctrl_d.channel_addr_bit1, ctrl_d.channel_addr_bit0};
      pos_d = chan_onehot(addr_d);
      if (ctrl_d.single_ended_select) begin
         neg_d = 6'h00;
      end else begin
         // pair partner: address with its low bit flipped
         neg_d = chan_onehot({addr_d[2:1], ~addr_d[0]});
      end
      if (addr_d >= 3'h6) begin
         neg_d = 6'h00;
      end
   end

   // analog switch controls, registered with the sequencer state
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         POS_SEL_OUT <= 6'h00;
         NEG_SEL_OUT <= 6'h00;
         NEG_COMMON_OUT <= 1'b0;
         CAP_TO_POS_OUT <= 1'b0;
         CAP_TO_NEG_OUT <= 1'b0;
         CONVERTING_OUT <= 1'b0;
      end else begin
         POS_SEL_OUT <= pos_d;
         NEG_SEL_OUT <= neg_d;
         NEG_COMMON_OUT <= ctrl_d.single_ended_select;
         // tracking: capacitor on the positive input only
         CAP_TO_POS_OUT <= (state_d == sar_ctrl_pkg::ST_TRACK_EXT ||
                            state_d == sar_ctrl_pkg::ST_TRACK_INT);
         // conversion: capacitor swapped to the negative input
         CAP_TO_NEG_OUT <= (state_d == sar_ctrl_pkg::ST_CONVERT);
         CONVERTING_OUT <= (state_d == sar_ctrl_pkg::ST_CONVERT);
      end
   end

endmodule : sar_adc_control_byte_track_hold

// ---- sim/sar_ctrl_checker.sv ----
// sar_ctrl_checker: port-level checks of the converter control block.
// assumes one clock domain; bound to the top module at the foot of this file.
`timescale 1ns/100ps

module sar_ctrl_checker (
   input wire logic CLOCK_IN,
   input wire logic RESET_N_IN,
   input wire logic CS_N_IN,
   input wire logic WR_N_IN,
   input wire logic [7:0] DATA_IN,
   input wire logic [5:0] POS_SEL_OUT,
   input wire logic [5:0] NEG_SEL_OUT,
   input wire logic NEG_COMMON_OUT,
   input wire logic CAP_TO_POS_OUT,
   input wire logic CAP_TO_NEG_OUT,
   input wire logic FULL_POWER_DOWN_OUT,
   input wire logic STANDBY_OUT,
   input wire logic INT_CLK_MODE_OUT,
   input wire logic CONVERTING_OUT,
   input wire logic [11:0] DAC_CODE_OUT,
   input wire logic RESULT_STROBE_OUT
);
   default clocking @(posedge CLOCK_IN); endclocking
   default disable iff (!RESET_N_IN);
   logic wr_n_q; // strobe level at the last edge
   logic [7:0] byte_q; // byte seen while the strobe is low
   logic [7:0] ctrl_q; // byte of the last accepted write
   logic int_acq_q; // tracking began with an internally timed write
   logic [7:0] trk_cnt_q; // cycles tracked since the last write
   logic wr_take; // write accepted at this edge
   assign wr_take = !CS_N_IN && WR_N_IN && !wr_n_q;
   // one-hot select for a channel address, empty for unused codes
   function automatic logic [5:0] onehot(input logic [2:0] a);
      return (a < 3'h6) ? (6'h01 << a) : 6'h00;
   endfunction : onehot
   // shadow of the write path and of the tracking time
   always_ff @(posedge CLOCK_IN or negedge RESET_N_IN) begin
      if (!RESET_N_IN) begin
         wr_n_q <= 1'b1;
         byte_q <= 8'h00;
         ctrl_q <= 8'hC0;
         int_acq_q <= 1'b0;
         trk_cnt_q <= 8'h00;
      end else begin
         wr_n_q <= WR_N_IN;
         if (!WR_N_IN && !CS_N_IN) begin // byte follows the pins while low
            byte_q <= DATA_IN;
         end
         if (wr_take) begin // a second external write is no internal start
            ctrl_q <= byte_q;
            int_acq_q <= !byte_q[5] && !(CAP_TO_POS_OUT && ctrl_q[5]);
            trk_cnt_q <= 8'h00;
         end else if (CAP_TO_POS_OUT && trk_cnt_q != 8'hFF) begin
            trk_cnt_q <= trk_cnt_q + 8'h01;
         end
      end
   end
   // accepted write, and the write that ends an external acquisition
   sequence wr_take_s;
      wr_take;
   endsequence
   sequence second_ext_s;
      wr_take_s ##0 (CAP_TO_POS_OUT && ctrl_q[5] && !byte_q[5]);
   endsequence
   chk_reset_state: assert property ($rose(RESET_N_IN) |->
      !INT_CLK_MODE_OUT && !CAP_TO_POS_OUT && DAC_CODE_OUT == 12'h800)
      else $error("state after reset is wrong");
   chk_track_start: assert property (wr_take_s ##0 byte_q[7]
      && !(CAP_TO_POS_OUT && ctrl_q[5] && !byte_q[5]) |=> CAP_TO_POS_OUT && !CAP_TO_NEG_OUT)
      else $error("write did not start tracking");
   chk_ext_hold: assert property (second_ext_s |=> CONVERTING_OUT && !CAP_TO_POS_OUT)
      else $error("second write did not hold");
   chk_int_hold: assert property ($rose(CONVERTING_OUT) && int_acq_q && INT_CLK_MODE_OUT
      |-> trk_cnt_q inside {[8'h46:8'h64]})
      else $error("internal acquisition length is wrong");
   chk_clock_mode: assert property (wr_take_s |=>
      INT_CLK_MODE_OUT == (ctrl_q[7] ? !ctrl_q[6] : $past(INT_CLK_MODE_OUT)))
      else $error("clock mode decode is wrong");
   chk_power_mode: assert property (wr_take_s |=>
      FULL_POWER_DOWN_OUT == (ctrl_q[7:6] == 2'h0) && STANDBY_OUT == (ctrl_q[7:6] == 2'h1))
      else $error("power mode decode is wrong");
   chk_channel_sel: assert property (wr_take_s ##0 byte_q[7] |=>
      POS_SEL_OUT == onehot(ctrl_q[2:0]) && NEG_COMMON_OUT == ctrl_q[4]
      && (ctrl_q[4] || NEG_SEL_OUT == onehot(ctrl_q[2:0] ^ 3'h1)))
      else $error("channel select is wrong");
   chk_result_end: assert property (RESULT_STROBE_OUT |->
      $fell(CONVERTING_OUT) ##1 !RESULT_STROBE_OUT)
      else $error("result strobe out of place");
   chk_cap_exclusive: assert property (!(CAP_TO_POS_OUT && CAP_TO_NEG_OUT)
      && CONVERTING_OUT == CAP_TO_NEG_OUT)
      else $error("hold capacitor on both sides");
endmodule : sar_ctrl_checker

bind sar_adc_control_byte_track_hold sar_ctrl_checker chk_u (
   .CLOCK_IN, .RESET_N_IN, .CS_N_IN, .WR_N_IN, .DATA_IN, .POS_SEL_OUT, .NEG_SEL_OUT,
   .NEG_COMMON_OUT, .CAP_TO_POS_OUT, .CAP_TO_NEG_OUT, .FULL_POWER_DOWN_OUT, .STANDBY_OUT,
   .INT_CLK_MODE_OUT, .CONVERTING_OUT, .DAC_CODE_OUT, .RESULT_STROBE_OUT);

// ---- sim/host_model.sv ----
// host_model: host processor on the write bus, its clock pin and the comparator.
// assumes the bench calls write_byte and sets target and ext_run.
`timescale 1ns/100ps

module host_model (
   input wire logic clock_in,
   input wire logic [11:0] dac_code_in,
   output logic cs_n_out,
   output logic wr_n_out,
   output logic [7:0] data_out,
   output logic conv_clk_out,
   output logic comparator_out
);
   logic ext_run; // clock pin runs only during external clock conversions
   logic [11:0] target; // input level expressed as a code
   logic [2:0] half_cnt; // cycles in the current clock half
   // keep the trial bit while the level reaches the trial code
   assign comparator_out = (target >= dac_code_in);
   initial begin
      cs_n_out = 1'b1;
      wr_n_out = 1'b1;
      data_out = 8'h00;
      conv_clk_out = 1'b0;
      ext_run = 1'b0;
      target = 12'h000;
      half_cnt = 3'h0;
   end
   // clock pin toggles every six cycles while running, else stands low
   always begin
      @(posedge clock_in);
      #1;
      if (ext_run) begin
         half_cnt = half_cnt + 3'h1;
         if (half_cnt == 3'h6) begin
            half_cnt = 3'h0;
            conv_clk_out = !conv_clk_out;
         end
      end else begin
         conv_clk_out = 1'b0;
      end
   end
   // one write: strobe low one cycle with data, then high with select still low
   task write_byte(input logic [7:0] b, input logic cs_n);
      @(posedge clock_in);
      #1;
      cs_n_out = cs_n;
      wr_n_out = 1'b0;
      data_out = (b[2:0] > 3'h5) ? {b[7:3], 3'h5} : b;
      @(posedge clock_in);
      #1;
      wr_n_out = 1'b1;
      @(posedge clock_in);
      #1;
      cs_n_out = 1'b1;
      data_out = ~data_out; // released bus no longer shows the byte
   endtask : write_byte
endmodule : host_model

// ---- sim/testbench.sv ----
// testbench: runs the converter control block through the host model.
// assumes the checker binds itself to the design.
`timescale 1ns/100ps

module testbench;
   logic clk;
   logic rst_n;
   logic cs_n, wr_n, conv_clk, cmp;
   logic [7:0] data;
   logic [5:0] pos_sel, neg_sel;
   logic neg_common, cap_pos, cap_neg, full_pd, standby, int_clk, converting, strobe;
   logic [11:0] dac_code, result;
   integer seed = 32'h222D44AE;
   int miscompares = 0;
   int checks_done = 0;
   int cycles = 0;
   host_model host_u (.clock_in(clk), .dac_code_in(dac_code), .cs_n_out(cs_n),
      .wr_n_out(wr_n), .data_out(data), .conv_clk_out(conv_clk), .comparator_out(cmp));
   sar_adc_control_byte_track_hold dut_u (.CLOCK_IN(clk), .RESET_N_IN(rst_n),
      .CS_N_IN(cs_n), .WR_N_IN(wr_n), .DATA_IN(data), .CONV_CLK_IN(conv_clk),
      .COMPARATOR_IN(cmp), .POS_SEL_OUT(pos_sel), .NEG_SEL_OUT(neg_sel),
      .NEG_COMMON_OUT(neg_common), .CAP_TO_POS_OUT(cap_pos), .CAP_TO_NEG_OUT(cap_neg),
      .FULL_POWER_DOWN_OUT(full_pd), .STANDBY_OUT(standby), .INT_CLK_MODE_OUT(int_clk),
      .CONVERTING_OUT(converting), .DAC_CODE_OUT(dac_code), .RESULT_OUT(result),
      .RESULT_STROBE_OUT(strobe));
   // expected one-hot select and result coding
   function automatic logic [5:0] exp_sel(input logic [2:0] a);
      return 6'h01 << a;
   endfunction : exp_sel
   function automatic logic [11:0] exp_result(input logic [11:0] t, input logic uni);
      return uni ? t : {~t[11], t[10:0]};
   endfunction : exp_result
   // compare and count
   task check(input logic [11:0] seen, input logic [11:0] exp, input string what);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask : check
   // wait a bounded time for the result strobe, then compare the result
   task wait_result(input logic [11:0] t, input logic uni);
      int n;
      n = 0;
      while (strobe !== 1'b1 && n < 800) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(strobe, 1'b1, "result strobe");
      check(result, exp_result(t, uni), "result");
      check(cap_neg, 1'b0, "hold released");
   endtask : wait_result
   // internally timed acquisition and conversion of one byte
   task run_int(input logic [7:0] b, input logic [11:0] t);
      host_u.target = t;
      host_u.write_byte(b, 1'b0);
      check(pos_sel, exp_sel(b[2:0]), "positive select");
      check(neg_sel, b[4] ? 6'h00 : exp_sel(b[2:0] ^ 3'h1), "negative select");
      check(neg_common, b[4], "common return");
      check(cap_pos, 1'b1, "tracking");
      check(cap_neg, 1'b0, "capacitor back on input");
      wait_result(t, b[3]);
   endtask : run_int
   // verdict and end of run
   task give_verdict;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : give_verdict
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   // hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles > 10000) begin
         miscompares++;
         give_verdict;
      end
   end
   initial begin
      logic [7:0] b;
      logic [11:0] t;
      int n;
      rst_n = 1'b0;
      repeat (3) @(posedge clk);
      #1;
      rst_n = 1'b1;
      check(int_clk, 1'b0, "clock mode after reset");
      check(dac_code, 12'h800, "trial after reset");
      $display("test reset done");
      // every channel, random input mode, range and level, end codes first
      for (int i = 0; i < 6; i++) begin
         b = {2'h2, 1'b0, 1'($random(seed)), 1'($random(seed)), 3'(i)};
         t = (i == 0) ? 12'hFFF : (i == 1) ? 12'h000 : 12'($random(seed));
         run_int(b, t);
         check(int_clk, 1'b1, "internal clock mode");
      end
      $display("test channels done");
      // external clock, two-write acquisition
      host_u.target = 12'h7FF;
      host_u.write_byte(8'hF9, 1'b0);
      check(int_clk, 1'b0, "external clock mode");
      repeat (20) @(posedge clk);
      #1;
      check(cap_pos, 1'b1, "still tracking");
      host_u.write_byte(8'hD9, 1'b0);
      check(converting, 1'b1, "hold at second write");
      host_u.ext_run = 1'b1;
      wait_result(12'h7FF, 1'b1);
      host_u.ext_run = 1'b0;
      $display("test external done");
      // power-down codes keep the clock mode
      host_u.write_byte(8'h3B, 1'b0);
      check(full_pd, 1'b1, "full power-down");
      check(int_clk, 1'b0, "mode kept in full power-down");
      host_u.write_byte(8'h98, 1'b0);
      host_u.write_byte(8'h58, 1'b0);
      check(standby, 1'b1, "standby");
      check(full_pd, 1'b0, "full power-down left");
      check(int_clk, 1'b1, "mode kept in standby");
      $display("test power-down done");
      // a write during conversion aborts it and starts a new acquisition
      host_u.target = 12'h123;
      host_u.write_byte(8'h9A, 1'b0);
      n = 0;
      while (converting !== 1'b1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      check(converting, 1'b1, "first conversion running");
      run_int(8'h8D, 12'hABC);
      $display("test abort done");
      // strobe without chip select is ignored
      host_u.write_byte(8'h98, 1'b1);
      check(cap_pos, 1'b0, "write without select");
      // reset again in mid-run
      rst_n = 1'b0;
      @(posedge clk);
      #1;
      rst_n = 1'b1;
      check(int_clk, 1'b0, "clock mode after second reset");
      check(result, 12'h000, "result after second reset");
      $display("test second reset done");
      give_verdict;
   end
endmodule : testbench
